// ---- verilog/rsil_pkg.sv ----
package rsil_pkg;

  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STRAP = 8'h08;
  localparam logic [7:0] REG_TERM = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;

  // control and status field positions
  localparam int CTRL_RESTART = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_ROM = 3;

  // strap field positions on the address/data bus
  localparam int STRAP_ROM_EN = 0;
  localparam int STRAP_OFFW = 1;
  localparam int STRAP_DEV_LO = 2;
  localparam int STRAP_ENDIAN = 4;
  localparam int STRAP_PLL_LO = 28;
  localparam int STRAP_VOLT = 31;

  // straps still honoured when the rom load is selected
  localparam logic [31:0] ROM_KEEP_MASK = 32'hF000_001F;

  // upper five bits of the rom serial address
  localparam logic [4:0] ROM_DEV_HI = 5'h14;

  // reset value, step size, last record byte, ack bit index
  localparam logic [31:0] TERM_RESET = 32'hFFFF_FFFF;
  localparam logic [15:0] OFFSET_STEP = 16'h0008;
  localparam logic [2:0] LAST_BYTE = 3'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // link clock cycles per quarter of a serial bit
  localparam logic [3:0] LINK_TICK_DIV = 4'h8;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} rsil_op_t;
  typedef enum logic [2:0] {LD_IDLE, LD_REQ, LD_WAIT, LD_DONE} rsil_ld_t;
  typedef enum logic [3:0] {
    LK_IDLE, LK_START, LK_DEVW, LK_OFFH, LK_OFFL, LK_RSTART, LK_DEVR, LK_READ, LK_STOP, LK_ACK
  } rsil_lk_t;

endpackage

// ---- verilog/rsil_byte_if.sv ----
`timescale 1ns/10ps
interface rsil_byte_if;
  import rsil_pkg::*;
  rsil_op_t op;
  logic op_valid;
  logic [7:0] wdata;
  logic send_nack;
  logic done;
  logic [7:0] rdata;
  logic nack;

  modport seq (output op, output op_valid, output wdata, output send_nack,
               input done, input rdata, input nack);
  modport eng (input op, input op_valid, input wdata, input send_nack,
               output done, output rdata, output nack);
endinterface

// ---- verilog/rsil_bit_engine.sv ----
`timescale 1ns/10ps
module rsil_bit_engine
  import rsil_pkg::*;
(
  input wire logic lclk,
  input wire logic lrst,
  rsil_byte_if.eng bus,
  input wire logic sda_i,
  output logic scl_oe_n,
  output logic sda_oe_n
);

  logic sda_meta_ff, sda_sync_ff;
  logic [3:0] pre_ff, nxt_pre;
  logic [1:0] q_ff, nxt_q;
  logic [3:0] bit_ff, nxt_bit;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic nack_ff, nxt_nack;
  logic [7:0] tx_ff, nxt_tx;
  logic [7:0] rx_ff, nxt_rx;
  logic scl_ff, nxt_scl;
  logic sda_ff, nxt_sda;
  logic tick;

  // line levels {scl, sda} for one quarter of the current bit
  function automatic logic [1:0] line_level(rsil_op_t op, logic [1:0] q, logic [3:0] b,
                                            logic [7:0] tx, logic nk);
    logic scl_hi;
    scl_hi = (q == 2'h1) || (q == 2'h2);
    case (op)
      OP_START: line_level = {scl_hi, (q < 2'h2)};
      OP_STOP: line_level = {(q != 2'h0), (q > 2'h1)};
      OP_WRITE: line_level = {scl_hi, (b == ACK_BIT) ? 1'h1 : tx[7]};
      OP_READ: line_level = {scl_hi, (b == ACK_BIT) ? nk : 1'h1};
      default: line_level = 2'h3;
    endcase
  endfunction

  // serial data pin sync, first stage read only by the second
  always_ff @(posedge lclk)
  begin
    sda_meta_ff <= sda_i;
    sda_sync_ff <= sda_meta_ff;
  end

  assign tick = (pre_ff == LINK_TICK_DIV - 4'h1);

  // bit sequencer: four quarters per bit, nine bits per byte
  always_comb
  begin
    nxt_pre = tick ? 4'h0 : pre_ff + 4'h1;
    nxt_q = q_ff;
    nxt_bit = bit_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'h0;
    nxt_nack = nack_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_scl = scl_ff;
    nxt_sda = sda_ff;
    if (!busy_ff)
    begin
      if (bus.op_valid && !done_ff)
      begin
        nxt_busy = 1'h1;
        nxt_q = 2'h0;
        nxt_bit = 4'h0;
        nxt_tx = bus.wdata;
        nxt_pre = 4'h0;
      end
    end
    else if (tick)
    begin
      {nxt_scl, nxt_sda} = line_level(bus.op, q_ff, bit_ff, tx_ff, bus.send_nack);
      nxt_q = q_ff + 2'h1;
      if (q_ff == 2'h2)
      begin
        if (bus.op == OP_WRITE && bit_ff == ACK_BIT)
          nxt_nack = sda_sync_ff;
        else if (bus.op == OP_READ && bit_ff != ACK_BIT)
          nxt_rx = {rx_ff[6:0], sda_sync_ff};
      end
      if (q_ff == 2'h3)
      begin
        nxt_tx = {tx_ff[6:0], 1'h0};
        nxt_bit = bit_ff + 4'h1;
        if (bus.op == OP_START || bus.op == OP_STOP || bit_ff == ACK_BIT)
        begin
          nxt_busy = 1'h0;
          nxt_done = 1'h1;
        end
      end
    end
  end

  always_ff @(posedge lclk)
  begin
    if (lrst)
    begin
      pre_ff <= 4'h0;
      q_ff <= 2'h0;
      bit_ff <= 4'h0;
      busy_ff <= 1'h0;
      done_ff <= 1'h0;
      nack_ff <= 1'h0;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      scl_ff <= 1'h1;
      sda_ff <= 1'h1;
    end
    else
    begin
      pre_ff <= nxt_pre;
      q_ff <= nxt_q;
      bit_ff <= nxt_bit;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      nack_ff <= nxt_nack;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      scl_ff <= nxt_scl;
      sda_ff <= nxt_sda;
    end
  end

  // open drain: enable low pulls the wire low
  assign scl_oe_n = scl_ff;
  assign sda_oe_n = sda_ff;
  assign bus.done = done_ff;
  assign bus.rdata = rx_ff;
  assign bus.nack = nack_ff;

endmodule

// ---- verilog/rsil_top.sv ----
// Operation
// - two start-up methods: straps only, or reduced straps plus serial rom load
// - strap-only mode latches address/data pins at reset release as mode settings
// - rom mode fetches contents over the two-wire bus after the strap sample
// - rom read sequentially in 8-byte records, address word then data word
// - each record writes its 32-bit data to its decoded 32-bit address
// - all-ones data item ends the load and is not written; the code ends on the REG_TERM value, which is all ones at reset
// - rom mode still samples bit 1 offset width and bits 3:2 rom address
// - rom mode still samples bit 4 endianness, 30:28 pll, 31 voltage
// - processor stays held in reset until the rom load has finished
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module rsil_top
  import rsil_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [31:0] ad_pins,
  output logic [31:0] strap_word,
  output logic cpu_big_endian,
  output logic [2:0] pll_cfg,
  output logic cpu_volt_sel,
  output logic cpu_reset_hold,
  output logic rom_init_in_progress,
  output logic cfg_wr_valid,
  output logic [31:0] cfg_wr_addr,
  output logic [31:0] cfg_wr_data,
  input wire logic link_clk,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);

  // strap pin sync and reset release capture
  logic [31:0] pin_meta_ff, pin_sync_ff;
  logic rst_prev_ff;
  logic start_ff;
  logic [31:0] strap_ff;

  always_ff @(posedge mclk)
  begin
    pin_meta_ff <= ad_pins;
    pin_sync_ff <= pin_meta_ff;
  end

  // straps latch on the first edge after reset release
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rst_prev_ff <= 1'h1;
      start_ff <= 1'h0;
      strap_ff <= 32'h0000_0000;
    end
    else
    begin
      rst_prev_ff <= 1'h0;
      start_ff <= rst_prev_ff;
      if (rst_prev_ff)
      begin
        if (pin_sync_ff[STRAP_ROM_EN])
          strap_ff <= pin_sync_ff & ROM_KEEP_MASK;
        else
          strap_ff <= pin_sync_ff;
      end
    end
  end

  assign strap_word = strap_ff;
  assign cpu_big_endian = strap_ff[STRAP_ENDIAN];
  assign pll_cfg = strap_ff[STRAP_PLL_LO +: 3];
  assign cpu_volt_sel = strap_ff[STRAP_VOLT];

  // ahb-lite slave: zero wait states, always okay
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] term_ff, nxt_term;
  logic restart_ff, nxt_restart;
  logic ready_ff;
  logic addr_ok;

  // loader state, declared here for the read mux
  rsil_ld_t ld_ff, nxt_ld;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic hold_ff, nxt_hold;
  logic err_ff, nxt_err;
  logic [15:0] offset_ff, nxt_offset;
  logic [31:0] count_ff, nxt_count;
  logic req_tgl_ff, nxt_req_tgl;
  logic wr_valid_ff, nxt_wr_valid;
  logic [31:0] wr_a_ff, nxt_wr_a;
  logic [31:0] wr_d_ff, nxt_wr_d;

  // read value of one register, unmapped offsets read zero
  function automatic logic [31:0] reg_read(logic [7:0] a, logic [31:0] st, logic [31:0] sw,
                                           logic [31:0] tm, logic [31:0] cn);
    case (a)
      REG_STATUS: reg_read = st;
      REG_STRAP: reg_read = sw;
      REG_TERM: reg_read = tm;
      REG_COUNT: reg_read = cn;
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  assign addr_ok = hsel && htrans[1] && hready;

  always_comb
  begin
    nxt_wr_pend = addr_ok && hwrite;
    nxt_wr_addr = addr_ok ? haddr[7:0] : wr_addr_ff;
    nxt_rdata = rdata_ff;
    if (addr_ok && !hwrite)
      nxt_rdata = reg_read(haddr[7:0],
                           {28'h0000000, strap_ff[STRAP_ROM_EN], err_ff, done_ff, busy_ff},
                           strap_ff, term_ff, count_ff);
    nxt_term = term_ff;
    nxt_restart = 1'h0;
    if (wr_pend_ff)
    begin
      if (wr_addr_ff == REG_TERM)
        nxt_term = hwdata;
      if (wr_addr_ff == REG_CTRL)
        nxt_restart = hwdata[CTRL_RESTART];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_pend_ff <= 1'h0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
      term_ff <= TERM_RESET;
      restart_ff <= 1'h0;
      ready_ff <= 1'h1;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
      term_ff <= nxt_term;
      restart_ff <= nxt_restart;
      ready_ff <= 1'h1;
    end
  end

  assign hreadyout = ready_ff;
  assign hresp = 1'h0;
  assign hrdata = rdata_ff;

  // handshake between loader and link sequencer
  logic ack_meta_ff, ack_sync_ff;
  logic lack_tgl_ff, nxt_lack_tgl;
  logic [63:0] rec_ff, nxt_rec;
  logic lerr_ff, nxt_lerr;

  always_ff @(posedge mclk)
  begin
    ack_meta_ff <= lack_tgl_ff;
    ack_sync_ff <= ack_meta_ff;
  end

  // loader: one record per handshake until the terminator
  always_comb
  begin
    nxt_ld = ld_ff;
    nxt_busy = busy_ff;
    nxt_done = done_ff;
    nxt_err = err_ff;
    nxt_offset = offset_ff;
    nxt_count = count_ff;
    nxt_req_tgl = req_tgl_ff;
    nxt_wr_valid = 1'h0;
    nxt_wr_a = wr_a_ff;
    nxt_wr_d = wr_d_ff;
    case (ld_ff)
      LD_IDLE:
        if (start_ff)
        begin
          if (strap_ff[STRAP_ROM_EN])
          begin
            nxt_busy = 1'h1;
            nxt_offset = 16'h0000;
            nxt_ld = LD_REQ;
          end
          else
          begin
            nxt_done = 1'h1;
            nxt_ld = LD_DONE;
          end
        end
      LD_REQ:
        // one offset byte cannot reach past 0xFF; end only after the last write has gone out
        if (!strap_ff[STRAP_OFFW] && offset_ff[15:8] != 8'h00)
        begin
          nxt_err = 1'h1;
          nxt_busy = 1'h0;
          nxt_done = 1'h1;
          nxt_ld = LD_DONE;
        end
        else
        begin
          nxt_req_tgl = ~req_tgl_ff;
          nxt_ld = LD_WAIT;
        end
      LD_WAIT:
        if (ack_sync_ff == req_tgl_ff)
        begin
          if (lerr_ff)
          begin
            nxt_err = 1'h1;
            nxt_busy = 1'h0;
            nxt_done = 1'h1;
            nxt_ld = LD_DONE;
          end
          else if (rec_ff[31:0] == term_ff)
          begin
            nxt_busy = 1'h0;
            nxt_done = 1'h1;
            nxt_ld = LD_DONE;
          end
          else
          begin
            nxt_wr_valid = 1'h1;
            nxt_wr_a = rec_ff[63:32];
            nxt_wr_d = rec_ff[31:0];
            nxt_count = count_ff + 32'h0000_0001;
            nxt_offset = offset_ff + OFFSET_STEP;
            nxt_ld = LD_REQ;
          end
        end
      LD_DONE:
        if (restart_ff && strap_ff[STRAP_ROM_EN])
        begin
          nxt_busy = 1'h1;
          nxt_done = 1'h0;
          nxt_err = 1'h0;
          nxt_offset = 16'h0000;
          nxt_count = 32'h0000_0000;
          nxt_ld = LD_REQ;
        end
      default: nxt_ld = LD_IDLE;
    endcase
    nxt_hold = !nxt_done;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ld_ff <= LD_IDLE;
      busy_ff <= 1'h0;
      done_ff <= 1'h0;
      hold_ff <= 1'h1;
      err_ff <= 1'h0;
      offset_ff <= 16'h0000;
      count_ff <= 32'h0000_0000;
      req_tgl_ff <= 1'h0;
      wr_valid_ff <= 1'h0;
      wr_a_ff <= 32'h0000_0000;
      wr_d_ff <= 32'h0000_0000;
    end
    else
    begin
      ld_ff <= nxt_ld;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      hold_ff <= nxt_hold;
      err_ff <= nxt_err;
      offset_ff <= nxt_offset;
      count_ff <= nxt_count;
      req_tgl_ff <= nxt_req_tgl;
      wr_valid_ff <= nxt_wr_valid;
      wr_a_ff <= nxt_wr_a;
      wr_d_ff <= nxt_wr_d;
    end
  end

  assign rom_init_in_progress = busy_ff;
  assign cpu_reset_hold = hold_ff;
  assign cfg_wr_valid = wr_valid_ff;
  assign cfg_wr_addr = wr_a_ff;
  assign cfg_wr_data = wr_d_ff;

  // link domain: reset and request synchronisers
  logic lrst_meta_ff, lrst_ff;
  logic req_meta_ff, req_sync_ff;

  always_ff @(posedge link_clk)
  begin
    lrst_meta_ff <= rst;
    lrst_ff <= lrst_meta_ff;
    req_meta_ff <= req_tgl_ff;
    req_sync_ff <= req_meta_ff;
  end

  // link sequencer: random read of one 8-byte record
  rsil_byte_if bif ();
  rsil_lk_t lk_ff, nxt_lk;
  logic [2:0] byte_ff, nxt_byte;
  logic [6:0] dev_addr;

  assign dev_addr = {ROM_DEV_HI, strap_ff[STRAP_DEV_LO +: 2]};

  always_comb
  begin
    nxt_lk = lk_ff;
    nxt_byte = byte_ff;
    nxt_rec = rec_ff;
    nxt_lerr = lerr_ff;
    nxt_lack_tgl = lack_tgl_ff;
    case (lk_ff)
      LK_IDLE:
        if (req_sync_ff != lack_tgl_ff)
        begin
          nxt_byte = 3'h0;
          nxt_lerr = 1'h0;
          nxt_lk = LK_START;
        end
      LK_START: if (bif.done) nxt_lk = LK_DEVW;
      LK_DEVW:
        if (bif.done)
          nxt_lk = bif.nack ? LK_STOP : (strap_ff[STRAP_OFFW] ? LK_OFFH : LK_OFFL);
      LK_OFFH: if (bif.done) nxt_lk = bif.nack ? LK_STOP : LK_OFFL;
      LK_OFFL: if (bif.done) nxt_lk = bif.nack ? LK_STOP : LK_RSTART;
      LK_RSTART: if (bif.done) nxt_lk = LK_DEVR;
      LK_DEVR: if (bif.done) nxt_lk = bif.nack ? LK_STOP : LK_READ;
      LK_READ:
        if (bif.done)
        begin
          nxt_rec = {rec_ff[55:0], bif.rdata};
          nxt_byte = byte_ff + 3'h1;
          if (byte_ff == LAST_BYTE)
            nxt_lk = LK_STOP;
        end
      LK_STOP: if (bif.done) nxt_lk = LK_ACK;
      LK_ACK:
      begin
        nxt_lack_tgl = ~lack_tgl_ff;
        nxt_lk = LK_IDLE;
      end
      default: nxt_lk = LK_IDLE;
    endcase
    if (bif.done && bif.nack && (lk_ff == LK_DEVW || lk_ff == LK_OFFH ||
        lk_ff == LK_OFFL || lk_ff == LK_DEVR))
      nxt_lerr = 1'h1;
  end

  always_ff @(posedge link_clk)
  begin
    if (lrst_ff)
    begin
      lk_ff <= LK_IDLE;
      byte_ff <= 3'h0;
      rec_ff <= 64'h0000_0000_0000_0000;
      lerr_ff <= 1'h0;
      lack_tgl_ff <= 1'h0;
    end
    else
    begin
      lk_ff <= nxt_lk;
      byte_ff <= nxt_byte;
      rec_ff <= nxt_rec;
      lerr_ff <= nxt_lerr;
      lack_tgl_ff <= nxt_lack_tgl;
    end
  end

  // byte operation for the current sequencer state
  always_comb
  begin
    bif.op_valid = (lk_ff != LK_IDLE) && (lk_ff != LK_ACK);
    bif.send_nack = (byte_ff == LAST_BYTE);
    bif.wdata = 8'h00;
    case (lk_ff)
      LK_START, LK_RSTART: bif.op = OP_START;
      LK_DEVW: bif.op = OP_WRITE;
      LK_OFFH: bif.op = OP_WRITE;
      LK_OFFL: bif.op = OP_WRITE;
      LK_DEVR: bif.op = OP_WRITE;
      LK_READ: bif.op = OP_READ;
      default: bif.op = OP_STOP;
    endcase
    case (lk_ff)
      LK_DEVW: bif.wdata = {dev_addr, 1'h0};
      LK_OFFH: bif.wdata = offset_ff[15:8];
      LK_OFFL: bif.wdata = offset_ff[7:0];
      LK_DEVR: bif.wdata = {dev_addr, 1'h1};
      default: bif.wdata = 8'h00;
    endcase
  end

  rsil_bit_engine u_engine (
    .lclk(link_clk),
    .lrst(lrst_ff),
    .bus(bif),
    .sda_i(sda_i),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n)
  );

  // open-drain pins only ever pull low
  assign scl_o = 1'h0;
  assign sda_o = 1'h0;

endmodule

// ---- test/rsil_properties.sv ----
`timescale 1ns/10ps
module rsil_properties
  import rsil_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [31:0] strap_word,
  input wire logic cpu_big_endian,
  input wire logic [2:0] pll_cfg,
  input wire logic cpu_volt_sel,
  input wire logic cpu_reset_hold,
  input wire logic rom_init_in_progress,
  input wire logic cfg_wr_valid,
  input wire logic [31:0] cfg_wr_addr,
  input wire logic [31:0] cfg_wr_data
);
  // all checks live in the system clock domain
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // strap decode and load gating
  a_skip_rom_load: assert property (
    !strap_word[STRAP_ROM_EN] |-> !rom_init_in_progress) else $error("load ran in strap mode");
  a_rom_strap_mask: assert property (
    strap_word[STRAP_ROM_EN] |-> (strap_word & ~ROM_KEEP_MASK) == 32'h0)
    else $error("strap bits kept outside mask");
  a_mode_outputs: assert property (
    {cpu_volt_sel, pll_cfg, cpu_big_endian} == {strap_word[31:28], strap_word[4]})
    else $error("mode outputs differ from straps");
  a_load_needs_rom: assert property (
    $rose(rom_init_in_progress) |-> strap_word[STRAP_ROM_EN]) else $error("load without rom strap");

  // processor reset hold around the load
  a_hold_on_write: assert property (
    cfg_wr_valid |-> cpu_reset_hold && rom_init_in_progress) else $error("write while released");
  a_release_hold: assert property (
    $fell(rom_init_in_progress) |-> ##[0:2] !cpu_reset_hold) else $error("hold not released");

  // record write strobe
  a_write_pulse: assert property (
    cfg_wr_valid |=> !cfg_wr_valid) else $error("write strobe longer than one cycle");
  a_no_term_write: assert property (
    cfg_wr_valid |-> cfg_wr_data != TERM_RESET) else $error("terminator was written");
  a_write_hold: assert property (
    $fell(cfg_wr_valid) |-> $stable(cfg_wr_addr) && $stable(cfg_wr_data))
    else $error("write address or data moved");

  // main scenarios
  c_rom_done: cover property ($fell(rom_init_in_progress));
  c_rec_write: cover property (cfg_wr_valid);
  c_strap_only: cover property ($fell(cpu_reset_hold) && !strap_word[STRAP_ROM_EN]);
endmodule

bind rsil_top rsil_properties prop_u (.mclk, .rst, .strap_word, .cpu_big_endian, .pll_cfg,
  .cpu_volt_sel, .cpu_reset_hold, .rom_init_in_progress, .cfg_wr_valid, .cfg_wr_addr,
  .cfg_wr_data);

// ---- test/rsil_rom_model.sv ----
`timescale 1ns/10ps
module rsil_rom_model
  import rsil_pkg::*;
(
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n
);
  logic [7:0] mem [0:255];
  logic [7:0] sh, ptr;
  logic act = 0, rd = 0, first = 0, refuse = 0, wide = 0, hi = 0;
  int cnt = 0;
  initial sda_oe_n = 1'b1;
  // start and stop seen while the clock line is high
  always @(negedge sda) if (scl === 1'b1) {act, rd, first, cnt, sda_oe_n} = {3'b101, 32'd0, 1'b1};
  always @(posedge sda) if (scl === 1'b1) act = 0;
  // shift in on the rising clock, nine bits to a byte; master nack ends a read
  always @(posedge scl) if (act)
  begin
    if (cnt < 8 && !rd) sh = {sh[6:0], sda};
    if (cnt == 8 && rd && sda) act = 0;
    cnt = (cnt == 8) ? 0 : cnt + 1;
  end
  // change the data line only while the clock line is low
  always @(negedge scl)
  begin
    if (!act) sda_oe_n = 1;
    else if (!rd && cnt == 8)
    begin
      // wide rom: a lone high offset byte leaves a wrong pointer behind
      if (!first && hi) {ptr, hi, sda_oe_n} = {~sh, 2'b00};
      else if (!first) {ptr, sda_oe_n} = {sh, 1'b0};
      else if (sh[7:1] == {ROM_DEV_HI, 2'b11} && !refuse)
        {rd, first, sda_oe_n, hi} = {sh[0], 2'b00, wide};
      else act = 0;
    end
    else if (cnt == 0 && rd)
    begin
      sh = mem[ptr];
      ptr = ptr + 8'h01;
      sda_oe_n = sh[7];
    end
    else if (cnt == 0) sda_oe_n = 1;
    else if (rd) sda_oe_n = (cnt == 8) ? 1'b1 : sh[7 - cnt];
  end
endmodule

// ---- test/rsil_top_tb.sv ----
`timescale 1ns/10ps
module rsil_top_tb
  import rsil_pkg::*;
;
  logic mclk = 0, rst = 1, link_clk = 0, hsel = 0, hwrite = 0, rd_dp = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, ad_pins = 32'h0;
  logic hreadyout, hresp, cpu_big_endian, cpu_volt_sel, cpu_reset_hold, rom_oe_n;
  logic rom_init_in_progress, cfg_wr_valid, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic [31:0] hrdata, strap_word, cfg_wr_addr, cfg_wr_data, ea [3], ed [3];
  logic [2:0] pll_cfg;
  logic [31:0] rq [$], aq [$], dq [$];
  int error_cnt = 0, checks = 0, cyc = 0;
  // open-drain wires with pull-ups
  wire logic scl_w = (scl_oe_n === 1'b0) ? 1'b0 : 1'b1;
  wire logic sda_w = (sda_oe_n === 1'b0 || rom_oe_n === 1'b0) ? 1'b0 : 1'b1;

  rsil_top dut_u (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ad_pins, .strap_word, .cpu_big_endian,
    .pll_cfg, .cpu_volt_sel, .cpu_reset_hold, .rom_init_in_progress, .cfg_wr_valid,
    .cfg_wr_addr, .cfg_wr_data, .link_clk, .scl_i(scl_w), .scl_o, .scl_oe_n, .sda_i(sda_w),
    .sda_o, .sda_oe_n);
  rsil_rom_model rom_u (.scl(scl_w), .sda(sda_w), .sda_oe_n(rom_oe_n));

  // system and link clocks, unrelated in phase
  initial forever #25 mclk = ~mclk;
  initial
  begin
    #7;
    forever #32 link_clk = ~link_clk;
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task summarize;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // wait for hready sampled high at a rising edge
  task wait_rdy;
    do
    begin
      @(posedge mclk);
    end while (hreadyout !== 1'b1);
  endtask

  // one single-word ahb-lite transfer
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    {hsel, hwrite, htrans, haddr} <= {1'b1, wr, 2'h2, a};
    wait_rdy();
    {hsel, htrans, hwdata, rd_dp} <= {1'b0, 2'h0, d, !wr};
    wait_rdy();
    rd_dp <= 1'b0;
  endtask

  task rd(input logic [31:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    ahb(1'b0, a, 32'h0);
  endtask

  task do_rst(input logic [31:0] pins);
    {rst, ad_pins} <= {1'b1, pins};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
  endtask

  task wait_idle;
    while (rom_init_in_progress !== 1'b0)
    begin
      @(posedge mclk);
    end
  endtask

  task push_exp;
    for (int i = 0; i < 3; i++)
    begin
      aq.push_back(ea[i]);
      dq.push_back(ed[i]);
    end
  endtask

  // result watcher: read data and record writes against the oldest notes
  always @(posedge mclk)
  begin
    cyc++;
    if (rd_dp && hreadyout === 1'b1)
    begin
      check("hrdata", hrdata, rq.pop_front());
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    if (cfg_wr_valid === 1'b1)
    begin
      check("cfg_wr_addr", cfg_wr_addr, aq.pop_front());
      check("cfg_wr_data", cfg_wr_data, dq.pop_front());
    end
    if (cyc == 90000)
    begin
      error_cnt++;
      summarize();
    end
  end

  // main sequence
  initial
  begin
    logic [31:0] p, a, d;
    p = $urandom(13704) & 32'hFFFF_FFFE;
    do_rst(p);
    repeat (6) @(posedge mclk);
    check("strap_word", strap_word, p);
    check("modes", {27'h0, cpu_volt_sel, pll_cfg, cpu_big_endian}, {27'h0, p[31:28], p[4]});
    check("hold", {31'h0, cpu_reset_hold}, 32'h0);
    rd(REG_STATUS, 32'h2);
    rd(REG_STRAP, p);
    ahb(1'b1, REG_CTRL, 32'h1);
    repeat (8) @(posedge mclk);
    rd(REG_COUNT, 32'h0);
    rd(32'h20, 32'h0);
    ahb(1'b1, REG_TERM, 32'h1234_5678);
    rd(REG_TERM, 32'h1234_5678);
    check("pin_out", {30'h0, scl_o, sda_o}, 32'h0);
    $display("test strap_only done");
    // records 0..2 real, 3 terminator, 4 beyond it
    for (int i = 0; i < 5; i++)
    begin
      a = $urandom;
      d = (i == 3) ? TERM_RESET : ($urandom & 32'h7FFF_FFFF);
      if (i < 3) {ea[i], ed[i]} = {a, d};
      for (int j = 0; j < 4; j++)
      begin
        rom_u.mem[8*i+j] = a[31-8*j -: 8];
        rom_u.mem[8*i+4+j] = d[31-8*j -: 8];
      end
    end
    push_exp();
    p = ($urandom & 32'hFFFF_FFF1) | 32'h0000_000D;
    do_rst(p);
    repeat (5) @(posedge mclk);
    check("busy_hold", {30'h0, rom_init_in_progress, cpu_reset_hold}, 32'h3);
    wait_idle();
    check("strap_word", strap_word, p & ROM_KEEP_MASK);
    check("modes", {27'h0, cpu_volt_sel, pll_cfg, cpu_big_endian}, {27'h0, p[31:28], p[4]});
    check("hold", {31'h0, cpu_reset_hold}, 32'h0);
    check("pending", 32'(aq.size()), 32'h0);
    rd(REG_STATUS, 32'hA);
    rd(REG_COUNT, 32'h3);
    rd(REG_TERM, TERM_RESET);
    rd(REG_STRAP, p & ROM_KEEP_MASK);
    $display("test rom_load done");
    rom_u.refuse = 1'b1;
    ahb(1'b1, REG_CTRL, 32'h1);
    repeat (5) @(posedge mclk);
    wait_idle();
    rd(REG_STATUS, 32'hE);
    check("hold", {31'h0, cpu_reset_hold}, 32'h0);
    $display("test refused_address done");
    rom_u.refuse = 1'b0;
    push_exp();
    ahb(1'b1, REG_CTRL, 32'h1);
    repeat (5) @(posedge mclk);
    wait_idle();
    check("pending", 32'(aq.size()), 32'h0);
    check("hold", {31'h0, cpu_reset_hold}, 32'h0);
    $display("test restart done");
    // two offset bytes: the model only answers right if both arrive
    rom_u.wide = 1'b1;
    p = p | 32'h0000_0002;
    push_exp();
    do_rst(p);
    repeat (5) @(posedge mclk);
    wait_idle();
    check("pending", 32'(aq.size()), 32'h0);
    rd(REG_STATUS, 32'hA);
    rd(REG_STRAP, p & ROM_KEEP_MASK);
    $display("test wide_offset done");
    summarize();
  end
endmodule
